// File: verif/ccr_asserts.sv
// Port assertions of the charger control register bank
`timescale 1ns/1ps
module ccr_asserts
    import ccr_pkg::*;
(
    // System side
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire ccr_status_s status_in,
    input wire logic        power_role_request_pin,
    input wire ccr_ctrl_s   ctrl_out,
    input wire logic        timer_restart_pulse,
    input wire logic        role_request_active,
    // Serial bus
    input wire logic        scl_clk,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe_n
);
    // Bus lines have no reset, so the idle check waits until the bus has moved
    int   ack_age = 99;
    int   idle    = -99999;
    logic scl_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    always_ff @(posedge clk_sys) begin
        scl_q   <= scl_clk;
        ack_age <= !sda_oe_n ? 0 : (ack_age < 99 ? ack_age + 1 : 99);
        idle    <= scl_clk != scl_q ? 0 : (idle < 99 ? idle + 1 : 99);
    end
    a_reset_values: assert property ($fell(srst) |-> ctrl_out == {8'h30, 8'h0A, 1'b1})
        else $error("control fields differ from reset values");
    a_pulse_single: assert property (timer_restart_pulse |=> !timer_restart_pulse)
        else $error("timer restart pulse longer than one cycle");
    a_pulse_cause: assert property (timer_restart_pulse |-> ack_age < 40)
        else $error("timer restart without a bus write");
    a_ctrl_cause: assert property ($changed(ctrl_out) && !$past(srst) |-> ack_age < 40)
        else $error("control fields changed without a bus write");
    a_role_level: assert property (($stable(power_role_request_pin) && $stable(ctrl_out)) [*6] |->
        role_request_active == (ctrl_out.role_pin_enable &&
        power_role_request_pin == ctrl_out.role_pin_polarity))
        else $error("role request level wrong");
    a_role_off: assert property (!ctrl_out.role_pin_enable [*4] |-> !role_request_active)
        else $error("role request active while pin disabled");
    a_sda_low_only: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_idle_release: assert property (idle > 8 |-> sda_oe_n)
        else $error("data line held low on an idle bus");
endmodule // ccr_asserts

// File: verif/ccr_host.sv
// Serial bus host model; its clock runs only inside frames
`timescale 1ns/1ps
module ccr_host
    import ccr_pkg::*;
(
    // Bus lines
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Data moves mid low phase, sampled mid high phase, 48 ns a bit
    task automatic bit_x(input logic b, output logic r);
        sda_m = b;
        #12 scl = 1'b1;
        #12 r = sda;
        #12 scl = 1'b0;
        #12;
    endtask
    task automatic send(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(v[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic start();
        sda_m = 1'b0;
        #24 scl = 1'b0;
        #12;
    endtask
    task automatic stop();
        sda_m = 1'b0;
        #12 scl = 1'b1;
        #12 sda_m = 1'b1;
        #24;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
                      output logic ok);
        logic k;
        start();
        send({a, 1'b0}, ok);
        send(p, k);
        send(v, k);
        stop();
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] v);
        logic k;
        start();
        send({CCR_DEV_ADDR, 1'b0}, k);
        send(p, k);
        stop();
        start();
        send({CCR_DEV_ADDR, 1'b1}, k);
        for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
        bit_x(1'b1, k);
        stop();
    endtask
endmodule // ccr_host

// File: verif/tb.sv
// Self-checking bench of the charger control register bank
`timescale 1ns/1ps
module tb;
    import ccr_pkg::*;
    logic        clk_sys = 1'b0, srst = 1'b1, pin = 1'b0, pulse, act, scl, sda_m, sda_out;
    logic        sda_oe_n, ok;
    ccr_status_s st = '0;
    ccr_ctrl_s   ctrl;
    logic [7:0]  m [4];
    logic [7:0]  d;
    logic [31:0] lf = 32'h302A;
    int          error_cnt = 0, checks = 0, pulses = 0, np, a;
    // Pull-up on the data line; low wins
    wire         sda = sda_m & (sda_oe_n | sda_out);
    ccr_regbank ccr_regbank_i (.clk_sys, .srst, .status_in(st), .power_role_request_pin(pin),
        .ctrl_out(ctrl), .timer_restart_pulse(pulse), .role_request_active(act),
        .scl_clk(scl), .sda_in(sda), .sda_out, .sda_oe_n);
    ccr_host ccr_host_i (.scl, .sda_m, .sda);
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (pulse === 1'b1) pulses++;
    initial begin
        #1000000;
        error_cnt++;
        conclude();
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input int r);
        ccr_host_i.rd(r[7:0], d);
        cmp(d, r == 0 ? {pin, m[0][6], st} : m[r]);
    endtask
    task automatic ctrl_chk();
        cmp(ctrl[16:9], m[1]);
        cmp(ctrl[8:1], m[2]);
        cmp({7'h00, ctrl[0]}, {7'h00, m[0][6]});
    endtask
    initial begin
        m = '{8'h40, 8'h30, 8'h0A, {CCR_MAKER_CODE, CCR_PART_CODE, CCR_REV_CODE}};
        repeat (20) @(posedge clk_sys);
        #2 srst = 1'b0;
        repeat (3) @(posedge clk_sys);
        ctrl_chk();
        for (a = 1; a < 4; a++) rd_chk(a);
        for (a = 0; a < 64; a++) begin
            @(posedge clk_sys);
            #2 st = a[5:0];
            pin = a[0];
            rd_chk(0);
        end
        ccr_host_i.wr(CCR_DEV_ADDR ^ 7'h01, 8'h01, 8'hFF, ok);
        repeat (8) @(posedge clk_sys);
        cmp({7'h00, ok}, 8'h00);
        ctrl_chk();
        for (int i = 0; i < 24; i++) begin
            lf = lfsr(lf);
            @(posedge clk_sys);
            #2 pin = lf[16];
            st = lf[15:10];
            np = pulses;
            a = lf[9:8];
            ccr_host_i.wr(CCR_DEV_ADDR, a[7:0], lf[7:0], ok);
            if (a == 1 || a == 2) m[a] = lf[7:0];
            if (a == 0) m[0][6] = lf[6];
            repeat (8) @(posedge clk_sys);
            cmp({7'h00, ok}, 8'h01);
            cmp(8'(pulses - np), {7'h00, a == 0 && lf[7]});
            ctrl_chk();
            cmp({7'h00, act}, {7'h00, m[2][0] & (pin == m[2][1])});
            rd_chk(a);
        end
        conclude();
    end
endmodule // tb
bind ccr_regbank ccr_asserts ccr_asserts_i (.clk_sys, .srst, .status_in,
    .power_role_request_pin, .ctrl_out, .timer_restart_pulse, .role_request_active,
    .scl_clk, .sda_in, .sda_out, .sda_oe_n);

// File: verilog/ccr_pkg.sv
// Package of the charger control register bank: offsets, reset values, types
package ccr_pkg;

    // Register offsets
    localparam logic [7:0] CCR_OFF_STATUS  = 8'h00;
    localparam logic [7:0] CCR_OFF_CTRL    = 8'h01;
    localparam logic [7:0] CCR_OFF_VBAT    = 8'h02;
    localparam logic [7:0] CCR_OFF_IDENT   = 8'h03;

    // Reset values
    localparam logic       CCR_RST_IND_EN  = 1'b1;
    localparam logic [7:0] CCR_RST_CTRL    = 8'h30;
    localparam logic [7:0] CCR_RST_VBAT    = 8'h0A;

    // Field positions
    localparam int CCR_POS_TMR     = 7;
    localparam int CCR_POS_IND_EN  = 6;
    localparam int CCR_POS_BOOST   = 3;

    // Identity: arbitrary neutral values
    localparam logic [2:0] CCR_MAKER_CODE = 3'h5;
    localparam logic [1:0] CCR_PART_CODE  = 2'h2;
    localparam logic [2:0] CCR_REV_CODE   = 3'h0;

    // Target address on the serial bus (arbitrary)
    localparam logic [6:0] CCR_DEV_ADDR   = 7'h6B;

    // Charge state codes
    localparam logic [1:0] CCR_ST_READY = 2'h0;
    localparam logic [1:0] CCR_ST_CHG   = 2'h1;
    localparam logic [1:0] CCR_ST_DONE  = 2'h2;
    localparam logic [1:0] CCR_ST_FAULT = 2'h3;

    // Status inputs from analog side
    typedef struct packed {
        logic [1:0] charge_state;
        logic       boost_active;
        logic [2:0] fault_code;
    } ccr_status_s;

    // Control outputs to analog side
    typedef struct packed {
        logic [1:0] input_limit;
        logic [1:0] weak_batt;
        logic       termination_enable;
        logic       charger_disable;
        logic       high_impedance_select;
        logic       operation_select;
        logic [5:0] regulation_voltage;
        logic       role_pin_polarity;
        logic       role_pin_enable;
        logic       indicator_enable;
    } ccr_ctrl_s;

endpackage

// File: verilog/ccr_regbank.sv
// Charger control register bank with a serial bus target on its own clock
`timescale 1ns/1ps

module ccr_regbank
    import ccr_pkg::*;
(
    // System side
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire ccr_status_s status_in,
    input  wire logic        power_role_request_pin,
    output ccr_ctrl_s        ctrl_out,
    output logic             timer_restart_pulse,
    output logic             role_request_active,
    // Serial bus, clocked by the bus clock
    input  wire logic        scl_clk,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n
);

    typedef enum logic [4:0] {
        CCR_S_IDLE = 5'b00001,
        CCR_S_ADDR = 5'b00010,
        CCR_S_PTR  = 5'b00100,
        CCR_S_WDAT = 5'b01000,
        CCR_S_RDAT = 5'b10000
    } ccr_state_e;

    // ---------------- Link domain (scl_clk) ----------------
    // Start and stop are sensed on sda edges while scl is high; those are
    // caught as toggles in sda-clocked flops and compared on scl.
    // The bus clock stops outside frames, so nothing can reset this side
    // on it; power-up values keep the toggles and the data line defined.
    logic       start_tgl_r  = 1'b0;
    logic       stop_tgl_r   = 1'b0;
    logic       start_seen_r = 1'b0;
    logic       stop_seen_r  = 1'b0;
    ccr_state_e st_r         = CCR_S_IDLE;
    logic [2:0] bit_cnt_r    = 3'h0;
    logic [7:0] shf_r;
    logic [7:0] ptr_r        = 8'h00;
    logic       ack_phase_r  = 1'b0;
    logic       first_rd_r   = 1'b0;
    logic       rw_r;
    logic [7:0] rd_byte_r;
    logic       wr_tgl_r     = 1'b0;
    logic [7:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic       drv_low_r    = 1'b0;

    // Sda falling while scl high is a start
    always_ff @(negedge sda_in) begin
        if (scl_clk) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    // Sda rising while scl high is a stop
    always_ff @(posedge sda_in) begin
        if (scl_clk) begin
            stop_tgl_r <= ~stop_tgl_r;
        end
    end

    // Register snapshot for reads, crossed as a level into scl domain
    logic [7:0] rd_img_sys_r [0:3];
    logic [7:0] rd_img_l1_r;
    logic [7:0] rd_img_l2_r;

    // Bit receive and protocol on scl rising edge
    always_ff @(posedge scl_clk) begin
        start_seen_r <= start_tgl_r;
        stop_seen_r  <= stop_tgl_r;
        rd_img_l1_r  <= rd_img_sys_r[ptr_r[1:0]];
        rd_img_l2_r  <= rd_img_l1_r;
        if (start_seen_r != start_tgl_r) begin
            st_r        <= CCR_S_ADDR;
            ack_phase_r <= 1'b0;
            first_rd_r  <= 1'b0;
            shf_r       <= {7'h00, sda_in};
            bit_cnt_r   <= 3'h1;
        end else if (stop_seen_r != stop_tgl_r) begin
            st_r <= CCR_S_IDLE;
        end else if (ack_phase_r) begin
            ack_phase_r <= 1'b0;
            bit_cnt_r   <= 3'h0;
            first_rd_r  <= 1'b0;
            // The address acknowledge of a read is ours; only a data
            // acknowledge left high by the host ends the read
            if (st_r == CCR_S_RDAT && sda_in && !first_rd_r) begin
                st_r <= CCR_S_IDLE;
            end
        end else begin
            unique case (st_r)
                CCR_S_IDLE: begin
                    bit_cnt_r <= 3'h0;
                end
                CCR_S_ADDR, CCR_S_PTR, CCR_S_WDAT: begin
                    shf_r     <= {shf_r[6:0], sda_in};
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    if (bit_cnt_r == 3'h7) begin
                        ack_phase_r <= 1'b1;
                        if (st_r == CCR_S_ADDR) begin
                            if (shf_r[6:0] != CCR_DEV_ADDR) begin
                                st_r        <= CCR_S_IDLE;
                                ack_phase_r <= 1'b0;
                            end else if (sda_in) begin
                                rw_r       <= 1'b1;
                                first_rd_r <= 1'b1;
                                st_r       <= CCR_S_RDAT;
                            end else begin
                                rw_r <= 1'b0;
                                st_r <= CCR_S_PTR;
                            end
                        end else if (st_r == CCR_S_PTR) begin
                            ptr_r <= {shf_r[6:0], sda_in};
                            st_r  <= CCR_S_WDAT;
                        end else begin
                            wr_addr_r <= ptr_r;
                            wr_data_r <= {shf_r[6:0], sda_in};
                            wr_tgl_r  <= ~wr_tgl_r;
                            ptr_r     <= ptr_r + 8'h01;
                        end
                    end
                end
                CCR_S_RDAT: begin
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    if (bit_cnt_r == 3'h7) begin
                        ack_phase_r <= 1'b1;
                        ptr_r       <= ptr_r + 8'h01;
                    end
                end
                default: st_r <= CCR_S_IDLE;
            endcase
        end
    end

    // Drive sda on scl falling edge: acknowledge or read data, msb first
    always_ff @(negedge scl_clk) begin
        if (st_r == CCR_S_RDAT && !ack_phase_r) begin
            if (bit_cnt_r == 3'h0) begin
                rd_byte_r <= {rd_img_l2_r[6:0], 1'b0};
                drv_low_r <= ~rd_img_l2_r[7];
            end else begin
                rd_byte_r <= {rd_byte_r[6:0], 1'b0};
                drv_low_r <= ~rd_byte_r[7];
            end
        end else if (ack_phase_r && (st_r != CCR_S_RDAT || first_rd_r)) begin
            drv_low_r <= 1'b1;
        end else begin
            drv_low_r <= 1'b0;
        end
    end

    // Open-drain: only ever pulls low; enable is active low
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drv_low_r;

    // ---------------- System domain (clk_sys) ----------------
    logic [2:0] wr_sync_r;
    logic [7:0] wr_addr_s_r;
    logic [7:0] wr_data_s_r;
    logic [1:0] pin_sync_r;
    logic       ind_en_r;
    logic [7:0] ctrl_r;
    logic [7:0] vbat_r;
    logic       tmr_pulse_r;
    logic       role_act_r;
    logic       wr_evt;

    always_ff @(posedge clk_sys) begin
        wr_sync_r  <= {wr_sync_r[1:0], wr_tgl_r};
        pin_sync_r <= {pin_sync_r[0], power_role_request_pin};
        // Address and data are stable long before the toggle arrives
        wr_addr_s_r <= wr_addr_r;
        wr_data_s_r <= wr_data_r;
    end

    assign wr_evt = wr_sync_r[2] ^ wr_sync_r[1];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ind_en_r    <= CCR_RST_IND_EN;
            ctrl_r      <= CCR_RST_CTRL;
            vbat_r      <= CCR_RST_VBAT;
            tmr_pulse_r <= 1'b0;
        end else begin
            tmr_pulse_r <= 1'b0;
            if (wr_evt) begin
                unique case (wr_addr_s_r)
                    CCR_OFF_STATUS: begin
                        // Bit 7 never stores; it only fires a restart
                        tmr_pulse_r <= wr_data_s_r[CCR_POS_TMR];
                        ind_en_r    <= wr_data_s_r[CCR_POS_IND_EN];
                    end
                    CCR_OFF_CTRL: ctrl_r <= wr_data_s_r;
                    CCR_OFF_VBAT: vbat_r <= wr_data_s_r;
                    default: ;
                endcase
            end
        end
    end

    // Role request: pin level qualified by polarity and enable
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            role_act_r <= 1'b0;
        end else begin
            role_act_r <= vbat_r[0] & (pin_sync_r[1] == vbat_r[1]);
        end
    end

    // Read images; fault field meaning follows the boost flag
    always_ff @(posedge clk_sys) begin
        rd_img_sys_r[0] <= {pin_sync_r[1], ind_en_r,
                            status_in.charge_state,
                            status_in.boost_active,
                            status_in.fault_code};
        rd_img_sys_r[1] <= ctrl_r;
        rd_img_sys_r[2] <= vbat_r;
        rd_img_sys_r[3] <= {CCR_MAKER_CODE, CCR_PART_CODE, CCR_REV_CODE};
    end

    always_ff @(posedge clk_sys) begin
        ctrl_out.input_limit           <= ctrl_r[7:6];
        ctrl_out.weak_batt             <= ctrl_r[5:4];
        ctrl_out.termination_enable    <= ctrl_r[3];
        ctrl_out.charger_disable       <= ctrl_r[2];
        ctrl_out.high_impedance_select <= ctrl_r[1];
        ctrl_out.operation_select      <= ctrl_r[0];
        ctrl_out.regulation_voltage    <= vbat_r[7:2];
        ctrl_out.role_pin_polarity     <= vbat_r[1];
        ctrl_out.role_pin_enable       <= vbat_r[0];
        ctrl_out.indicator_enable      <= ind_en_r;
    end

    assign timer_restart_pulse = tmr_pulse_r;
    assign role_request_active = role_act_r;

endmodule // ccr_regbank
